// >>> tb/spwm_core_monitor.sv
`timescale 1ns/1ps
module spwm_core_monitor(
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire run_i,
	input wire slave_mode_i,
	input wire [5:0] trap_level_i,
	input wire [3:0] event_en_i,
	input wire [2:0] capture_trigger_input_i,
	input wire protective_stop_input_i,
	input wire [5:0] waveform_output_o,
	input wire sync_out_o,
	input wire trans_enable_out_o,
	input wire trapped_o,
	input wire running_o,
	input wire [3:0] event_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence trap_hold;
		(trapped_o&&$stable(trap_level_i))[*3];
	endsequence
	sync_one_a: assert property (sync_out_o|=>!sync_out_o) else $error("sync wide");
	trans_pair_a: assert property (trans_enable_out_o|->sync_out_o) else $error("lone load");
	trap_set_a: assert property (protective_stop_input_i|->##[1:2] trapped_o)
		else $error("no trap");
	trap_lvl_a: assert property (trap_hold|->waveform_output_o==trap_level_i)
		else $error("trap level");
	run_off_a: assert property (!run_i[*2]|->!running_o) else $error("runs");
	run_on_a: assert property ($rose(run_i)&&!slave_mode_i|=>running_o) else $error("no run");
	cap_evt_a: assert property ($rose(capture_trigger_input_i[0])&&event_en_i[1]
		|->##[1:2] event_o[1]) else $error("no capture");
	slave_mute_a: assert property (slave_mode_i[*4]|->!sync_out_o) else $error("slave sync");
endmodule // spwm_core_monitor
bind spwm_core spwm_core_monitor u_mon(.clk_sys_i,.rst_n_i,.run_i,.slave_mode_i,.trap_level_i,
	.event_en_i,.capture_trigger_input_i,.protective_stop_input_i,.waveform_output_o,
	.sync_out_o,.trans_enable_out_o,.trapped_o,.running_o,.event_o);

// >>> tb/spwm_core_tb.sv
`timescale 1ns/1ps
module spwm_core_tb;
	reg clk=0,rst_n=0,run=0,upd=0,slv=0,stp=0,clr=0,ro=0;
	reg [7:0] dly=0;
	wire [47:0] cv;
	wire [3:0] ev;
	reg [15:0] pre=0,per=2;
	reg [95:0] rv=0,fv=0;
	reg [5:0] tl=0;
	reg [2:0] cap=0;
	wire [5:0] wo;
	wire so,to,tr,rn,pe,pt;
	int fail_count=0,tests_run=0,cyc=0,last=-1,nso=0,hc=0,eh=0,et=0,r,f,L;
	int q[$];
	spwm_core u_dut(.clk_sys_i(clk),.rst_n_i(rst_n),.run_i(run),.run_once_i(ro),
		.slave_mode_i(slv),.prescale_i(pre),.period_i(per),.rise_val_i(rv),.fall_val_i(fv),
		.update_req_i(upd),.sync_delay_i(dly),.trap_level_i(tl),.trap_clear_i(clr),
		.event_en_i(4'hF),.capture_trigger_input_i(cap),.protective_stop_input_i(stp),
		.sync_in_i(pe),.trans_enable_in_i(pt),.waveform_output_o(wo),.capture_val_o(cv),
		.sync_out_o(so),.trans_enable_out_o(to),.trapped_o(tr),.running_o(rn),.event_o(ev));
	spwm_partner u_prt(.clk_sys_i(clk),.en_i(slv),.sync_o(pe),.trans_o(pt));
	initial forever #2 clk=~clk;
	task chk(input logic [31:0] s,e,input string n);
		tests_run++;
		if(s!==e) begin
			fail_count++;
			$display("[ERR] %s exp %0h got %0h",n,e,s);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d",tests_run,fail_count);
		if(fail_count==0&&tests_run>0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(negedge clk) begin
		cyc++;
		hc+=$countones(wo);
		if(so) nso++;
		if(so&&last>=0&&q.size()>0) begin
			chk(cyc-last,q.pop_front(),"period");
			chk(hc,eh,"high time");
			if(to||et==0) chk(to,et,"load");
			if(to) et=0;
		end
		if(so||!rn) hc=0;
		if(so) last=cyc;
		if(!rn) last=-1;
		if(cyc>5000) begin
			fail_count++;
			end_of_test;
		end
	end
	initial begin
		void'($urandom(32'h1a340624));
		repeat(20) @(negedge clk);
		rst_n=1;
		pre=$urandom%3;
		per=2+$urandom%5;
		L=(pre+1)*(per+1);
		dly=$urandom%3;
		for(int g=0;g<6;g++) begin
			r=$urandom%per;
			f=r+1+$urandom%(per-r);
			rv[g*16+:16]=r;
			fv[g*16+:16]=f;
			eh+=(f-r)*(pre+1);
		end
		repeat(8) q.push_back(L);
		run=1;
		repeat(4*L) begin
			@(negedge clk);
			cap=$urandom;
		end
		while(!so) @(negedge clk);
		@(negedge clk);
		upd=1;
		et=1;
		@(negedge clk);
		upd=0;
		repeat(3*L) @(negedge clk);
		chk(nso>=6,1,"pulses");
		chk(et,0,"load seen");
		$display("master done");
		ro=1;
		repeat(2*L+6) @(negedge clk);
		chk(rn,0,"run once");
		cap=0;
		@(negedge clk);
		cap=7;
		@(negedge clk);
		for(int i=0;i<3;i++) chk(cv[i*16+:16],per,"capture");
		chk(ev[1],1,"capture event");
		$display("run once done");
		ro=0;
		run=0;
		tl=$urandom;
		stp=1;
		@(negedge clk);
		chk(ev[3],1,"trap event");
		repeat(3) @(negedge clk);
		chk(tr,1,"trapped");
		chk(wo,tl,"trap level");
		stp=0;
		clr=1;
		@(negedge clk);
		clr=0;
		@(negedge clk);
		chk(tr,0,"released");
		$display("trap done");
		slv=1;
		run=1;
		nso=0;
		repeat(100) @(negedge clk);
		chk(nso,0,"slave sync");
		chk(rn,1,"slave run");
		$display("slave done");
		end_of_test;
	end
endmodule // spwm_core_tb

// >>> tb/spwm_partner.sv
`timescale 1ns/1ps
module spwm_partner(
	input wire clk_sys_i,
	input wire en_i,
	output reg sync_o,
	output reg trans_o
);
	reg [3:0] cnt_ff=4'h0;
	always @(posedge clk_sys_i) begin
		cnt_ff<=en_i?cnt_ff+4'h1:4'h0;
		sync_o<=en_i&&cnt_ff==4'hF;
		trans_o<=en_i&&cnt_ff==4'hF;
	end
endmodule // spwm_partner

// >>> verilog/spwm_core.v
// Functional notes
// - 16-bit prescale counter drives a 16-bit period counter for long periods.
// - Prescaler makes each period step last a selected number of clocks.
// - Each output has independent rise and fall counter values.
// - Six match outputs, each a waveform from the shared period counter.
// - Three capture inputs latch the period counter on a rising event.
// - Control settings held apart from the counter domain logic.
// - Both counters step on the module clock; all timing in its periods.
// - Counters run on the same clock as the bus-side control.
// - Master emits a one-clock period-start pulse at each counter restart.
// - Master emits shadow-load pulse with period-start only when shadows loaded.
// - Programmable delay before both period-start and shadow-load pulses.
// - Slave restarts on incoming period-start, loads shadows on incoming load.
// - Master sync outputs feed the slave modules' sync inputs; a slave drives no sync outputs.
// - Continuous mode restarts every period; run-once stops a master after one, a slave ignores it.
// - Trap input forces outputs to programmed safe levels, optional event.
// - Match, capture, overflow and trap events, each individually enabled.
`timescale 1ns/1ps
`include "spwm_defines.vh"
module spwm_core #(
	parameter CW = `SPWM_CNT_W,
	parameter NM = `SPWM_NUM_MAT,
	parameter NC = `SPWM_NUM_CAP,
	parameter DW = `SPWM_DLY_W
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire run_i,
	input wire run_once_i,
	input wire slave_mode_i,
	input wire [CW-1:0] prescale_i,
	input wire [CW-1:0] period_i,
	input wire [NM*CW-1:0] rise_val_i,
	input wire [NM*CW-1:0] fall_val_i,
	input wire update_req_i,
	input wire [DW-1:0] sync_delay_i,
	input wire [NM-1:0] trap_level_i,
	input wire trap_clear_i,
	input wire [`SPWM_IRQ_W-1:0] event_en_i,
	input wire [NC-1:0] capture_trigger_input_i,
	input wire protective_stop_input_i,
	input wire sync_in_i,
	input wire trans_enable_in_i,
	output reg [NM-1:0] waveform_output_o,
	output reg [NC*CW-1:0] capture_val_o,
	output reg sync_out_o,
	output reg trans_enable_out_o,
	output reg trapped_o,
	output reg running_o,
	output reg [`SPWM_IRQ_W-1:0] event_o
);
	// Bus-side settings are captured here; period and match logic see shadows, the prescaler compares against prescale_i directly
	reg [CW-1:0] psc_cnt_ff;
	reg [CW-1:0] per_cnt_ff;
	reg [CW-1:0] per_sh_ff;
	reg [NM*CW-1:0] rise_sh_ff;
	reg [NM*CW-1:0] fall_sh_ff;
	reg upd_pend_ff;
	reg [NC-1:0] cap_prev_ff;
	reg [DW-1:0] dly_cnt_ff;
	reg dly_busy_ff;
	reg dly_load_ff;
	reg [NM-1:0] wave_ff;
	wire step;
	wire wrap;
	wire restart;
	wire do_load;
	wire [NM-1:0] mat_rise;
	wire [NM-1:0] mat_fall;
	wire [NC-1:0] cap_edge;
	wire trap_set;
	wire fire;
	wire fire_load;
	wire dly_zero;
	wire dly_last;
	wire [NM-1:0] nxt_wave;
	wire [NM-1:0] nxt_wo;
	wire [NC*CW-1:0] nxt_cap;

	assign step = running_o && (psc_cnt_ff >= prescale_i);
	assign wrap = step && (per_cnt_ff >= per_sh_ff);
	// Slave restart comes only from the chain input
	assign restart = slave_mode_i ? (sync_in_i && run_i) : (wrap && !run_once_i);
	assign do_load = slave_mode_i ? trans_enable_in_i : (restart && upd_pend_ff);
	assign cap_edge = capture_trigger_input_i & ~cap_prev_ff;
	assign trap_set = protective_stop_input_i;
	assign dly_zero = (sync_delay_i == {DW{1'b0}});
	assign dly_last = dly_busy_ff && (dly_cnt_ff == {{(DW-1){1'b0}}, 1'b1});
	assign fire = dly_zero ? (restart && !slave_mode_i) : dly_last;
	assign fire_load = dly_zero ? do_load : dly_load_ff;

	genvar g;
	generate
		for (g = 0; g < NM; g = g + 1) begin : g_mat
			assign mat_rise[g] = step && (per_cnt_ff == rise_sh_ff[g*CW +: CW]);
			assign mat_fall[g] = step && (per_cnt_ff == fall_sh_ff[g*CW +: CW]);
			// Fall wins when rise and fall land on one step
			assign nxt_wave[g] = mat_fall[g] ? 1'b0 :
				(mat_rise[g] ? 1'b1 : wave_ff[g]);
			assign nxt_wo[g] = trapped_o ? trap_level_i[g] : wave_ff[g];
		end
		for (g = 0; g < NC; g = g + 1) begin : g_cap
			assign nxt_cap[g*CW +: CW] = cap_edge[g] ? per_cnt_ff :
				capture_val_o[g*CW +: CW];
		end
	endgenerate

	// Waveform and capture registers
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wave_ff <= {NM{1'b0}};
			waveform_output_o <= {NM{1'b0}};
			capture_val_o <= {NC*CW{1'b0}};
		end else begin
			wave_ff <= nxt_wave;
			waveform_output_o <= nxt_wo;
			capture_val_o <= nxt_cap;
		end
	end

	// Counter domain on the single module clock
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			psc_cnt_ff <= `SPWM_CNT_RST;
			per_cnt_ff <= `SPWM_CNT_RST;
			running_o <= 1'b0;
		end else begin
			if (!run_i) begin
				running_o <= 1'b0;
				psc_cnt_ff <= `SPWM_CNT_RST;
				per_cnt_ff <= `SPWM_CNT_RST;
			end else if (restart) begin
				running_o <= 1'b1;
				psc_cnt_ff <= `SPWM_CNT_RST;
				per_cnt_ff <= `SPWM_CNT_RST;
			end else if (wrap && slave_mode_i) begin
				// Slave wraps to zero quietly and keeps counting until the next chain pulse restarts it
				psc_cnt_ff <= `SPWM_CNT_RST;
				per_cnt_ff <= `SPWM_CNT_RST;
			end else if (wrap) begin
				running_o <= 1'b0;
			end else if (!running_o && !slave_mode_i && per_cnt_ff == `SPWM_CNT_RST &&
				psc_cnt_ff == `SPWM_CNT_RST) begin
				running_o <= 1'b1;
			end else if (step) begin
				psc_cnt_ff <= `SPWM_CNT_RST;
				per_cnt_ff <= per_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
			end else if (running_o) begin
				psc_cnt_ff <= psc_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

	// Shadow registers and pending update
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			per_sh_ff <= `SPWM_CNT_RST;
			rise_sh_ff <= {NM*CW{1'b0}};
			fall_sh_ff <= {NM*CW{1'b0}};
			upd_pend_ff <= 1'b0;
		end else begin
			// A stopped counter lets the shadows follow the inputs
			if (do_load || !running_o) begin
				per_sh_ff <= period_i;
				rise_sh_ff <= rise_val_i;
				fall_sh_ff <= fall_val_i;
			end
			if (update_req_i)
				upd_pend_ff <= 1'b1;
			else if (do_load)
				upd_pend_ff <= 1'b0;
		end
	end

	// Sync outputs with delay, and trap
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			dly_cnt_ff <= {DW{1'b0}};
			dly_busy_ff <= 1'b0;
			dly_load_ff <= 1'b0;
			sync_out_o <= 1'b0;
			trans_enable_out_o <= 1'b0;
			trapped_o <= 1'b0;
		end else begin
			// Delay countdown reloads if a new restart arrives early
			if (restart && !slave_mode_i && !dly_zero) begin
				dly_cnt_ff <= sync_delay_i;
				dly_busy_ff <= 1'b1;
				dly_load_ff <= do_load;
			end else if (dly_busy_ff) begin
				dly_cnt_ff <= dly_cnt_ff - {{(DW-1){1'b0}}, 1'b1};
				if (dly_cnt_ff == {{(DW-1){1'b0}}, 1'b1})
					dly_busy_ff <= 1'b0;
			end
			sync_out_o <= fire && !slave_mode_i;
			trans_enable_out_o <= fire && !slave_mode_i && fire_load;
			// Trap set wins over a clear in the same cycle
			if (trap_set)
				trapped_o <= 1'b1;
			else if (trap_clear_i)
				trapped_o <= 1'b0;
		end
	end

	// Event pulses, one clock wide, each gated by its own enable
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cap_prev_ff <= {NC{1'b0}};
			event_o <= {`SPWM_IRQ_W{1'b0}};
		end else begin
			cap_prev_ff <= capture_trigger_input_i;
			event_o[`SPWM_IRQ_MATCH] <= event_en_i[`SPWM_IRQ_MATCH] &&
				|(mat_rise | mat_fall);
			event_o[`SPWM_IRQ_CAPTURE] <= event_en_i[`SPWM_IRQ_CAPTURE] && |cap_edge;
			event_o[`SPWM_IRQ_OVERFLOW] <= event_en_i[`SPWM_IRQ_OVERFLOW] && wrap;
			event_o[`SPWM_IRQ_TRAP] <= event_en_i[`SPWM_IRQ_TRAP] && trap_set &&
				!trapped_o;
		end
	end
endmodule // spwm_core

// >>> verilog/spwm_defines.vh
`ifndef SPWM_DEFINES_VH
`define SPWM_DEFINES_VH
`define SPWM_CNT_W 16
`define SPWM_NUM_MAT 6
`define SPWM_NUM_CAP 3
`define SPWM_DLY_W 8
`define SPWM_CNT_RST 16'h0000
`define SPWM_IRQ_MATCH 0
`define SPWM_IRQ_CAPTURE 1
`define SPWM_IRQ_OVERFLOW 2
`define SPWM_IRQ_TRAP 3
`define SPWM_IRQ_W 4
`endif
